/* File: src/legacy_mmio_queue_regs.sv */
`timescale 1ns/1ps
// Purpose: Legacy memory-mapped register front end for a virtual I/O device.
// Assumes: Simple synchronous word bus, one-cycle registered read data.
// Notes: Unmapped reads return zero; unmapped writes are dropped.
module legacy_mmio_queue_regs (
	input  wire logic                          mclk,
	input  wire logic                          reset,
	input  wire logic                          busSel,
	input  wire logic                          busWrite,
	input  wire logic [11:0]                   busAddr,
	input  wire logic [31:0]                   busWdata,
	output logic      [31:0]                   busRdata,
	output logic                               busRvalid,
	input  wire logic [queue_regs_pkg::NUM_QUEUES*16-1:0] queueSizeLimits,
	input  wire logic                          usedEvent,
	input  wire logic                          configEvent,
	output logic                               irqOut,
	output logic                               kickValid,
	output logic      [31:0]                   kickQueue,
	output logic      [63:0]                   queueBaseAddr,
	output logic      [31:0]                   queueAlignOut,
	output logic                               deviceReset
);
	import queue_regs_pkg::*;

	typedef struct packed {
		logic [QIDX_W-1:0]              sel;
		logic [31:0]                    pageBytes;
		logic [31:0]                    status;
		logic [1:0]                     irqFlags;
		logic [CONFIG_WORDS-1:0][31:0]  cfg;
		logic [31:0]                    rdata;
		logic                           rvalid;
		logic                           kick;
		logic [31:0]                    kickIdx;
		logic                           devRst;
	} front_state_t;

	front_state_t fs_r;
	front_state_t fs_nxt;

	queue_store_if qs ();

	// Word-aligned hit test on a byte offset
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction : hit

	// Size limit lookup for one queue; zero marks it unavailable
	function automatic logic [31:0] limitOf(input logic [QIDX_W-1:0] i,
		input logic [NUM_QUEUES*16-1:0] v);
		limitOf = {16'h0000, v[i*16 +: 16]};
	endfunction : limitOf

	wire logic wr      = busSel && busWrite;
	wire logic rd      = busSel && !busWrite;
	wire logic zeroSt  = wr && hit(busAddr, OFF_STATUS) && (busWdata == RST_ZERO);
	wire logic cfgHit  = (busAddr >= OFF_CONFIG) && (busAddr < OFF_CONFIG + 12'(CONFIG_WORDS*4));
	wire logic [1:0] cfgIdx = busAddr[3:2];

	// Strobes toward the store: writes hit the selected queue only, clearAll clears every queue's frame
	assign qs.index    = fs_r.sel;
	assign qs.wdata    = busWdata;
	assign qs.wrFrame  = wr && hit(busAddr, OFF_QPFN);
	assign qs.wrSize   = wr && hit(busAddr, OFF_QNUM);
	assign qs.wrAlign  = wr && hit(busAddr, OFF_QALIGN);
	assign qs.clearAll = zeroSt;

	queue_store u_store (
		.mclk  (mclk),
		.reset (reset),
		.qs    (qs)
	);

	// Bus decode, status, interrupt flags and configuration words
	always_comb begin
		fs_nxt        = fs_r;
		fs_nxt.rvalid = rd;
		fs_nxt.kick   = 1'b0;
		fs_nxt.devRst = zeroSt;
		fs_nxt.rdata  = RST_ZERO;
		if (wr) begin
			if (hit(busAddr, OFF_QSEL))
				fs_nxt.sel = busWdata[QIDX_W-1:0];
			else if (hit(busAddr, OFF_PAGE_BYTES))
				fs_nxt.pageBytes = busWdata;
			else if (hit(busAddr, OFF_STATUS))
				fs_nxt.status = busWdata;
			else if (hit(busAddr, OFF_KICK)) begin
				fs_nxt.kick    = 1'b1;
				fs_nxt.kickIdx = busWdata;
			end else if (hit(busAddr, OFF_IRQ_CLEAR))
				fs_nxt.irqFlags = fs_r.irqFlags & ~busWdata[1:0];
			else if (cfgHit)
				fs_nxt.cfg[cfgIdx] = busWdata;
		end
		// Late events win over a same-cycle acknowledge
		if (usedEvent)
			fs_nxt.irqFlags = fs_nxt.irqFlags | IRQ_USED_BIT;
		if (configEvent)
			fs_nxt.irqFlags = fs_nxt.irqFlags | IRQ_CFG_BIT;
		if (zeroSt) begin
			fs_nxt.sel      = '0;
			fs_nxt.irqFlags = '0;
		end
		if (rd) begin
			if (hit(busAddr, OFF_QPFN))
				fs_nxt.rdata = qs.entry.pageFrame;
			else if (hit(busAddr, OFF_QMAX))
				fs_nxt.rdata = limitOf(fs_r.sel, queueSizeLimits);
			else if (hit(busAddr, OFF_STATUS))
				fs_nxt.rdata = fs_r.status;
			else if (hit(busAddr, OFF_IRQ_FLAGS))
				fs_nxt.rdata = {30'h0, fs_r.irqFlags};
			else if (cfgHit)
				fs_nxt.rdata = fs_r.cfg[cfgIdx];
		end
	end

	// State register; page size reset is a plain default
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fs_r           <= '0;
			fs_r.pageBytes <= RST_PAGE_BYTES;
		end else
			fs_r <= fs_nxt;
	end

	// Base address uses a multiply so non-power-of-two sizes still give a value
	assign queueBaseAddr = 64'(qs.entry.pageFrame) * 64'(fs_r.pageBytes);
	assign queueAlignOut = qs.entry.alignment;
	assign busRdata      = fs_r.rdata;
	assign busRvalid     = fs_r.rvalid;
	assign irqOut        = |fs_r.irqFlags;
	assign kickValid     = fs_r.kick;
	assign kickQueue     = fs_r.kickIdx;
	assign deviceReset   = fs_r.devRst;

	sequence s_zero_status;
		wr && hit(busAddr, OFF_STATUS) && (busWdata == 32'h0);
	endsequence
	sequence s_read_frame;
		rd && hit(busAddr, OFF_QPFN);
	endsequence
	sequence s_read_max;
		rd && hit(busAddr, OFF_QMAX);
	endsequence

	// Readback checks expect the idle cycle a master leaves after each write

	property p_reset_clears;
		@(posedge mclk) disable iff (reset)
		s_zero_status ##1 !busSel ##1 s_read_frame |=> busRvalid && (busRdata == 32'h0);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("frame nonzero after reset");

	property p_status_rb;
		@(posedge mclk) disable iff (reset)
		(wr && hit(busAddr, OFF_STATUS)) ##1 !busSel ##1 (rd && hit(busAddr, OFF_STATUS))
		|=> busRdata == $past(busWdata, 3);
	endproperty
	a_status_rb: assert property (p_status_rb) else $error("status readback wrong");

	property p_frame_rb;
		@(posedge mclk) disable iff (reset)
		(qs.wrFrame && !qs.clearAll) ##1 !busSel ##1 s_read_frame
		|=> busRdata == $past(busWdata, 3);
	endproperty
	a_frame_rb: assert property (p_frame_rb) else $error("frame readback wrong");

	property p_select;
		@(posedge mclk) disable iff (reset)
		(wr && hit(busAddr, OFF_QSEL) && !zeroSt) |=> qs.index == $past(busWdata[QIDX_W-1:0]);
	endproperty
	a_select: assert property (p_select) else $error("select not taken");

	property p_max;
		@(posedge mclk) disable iff (reset)
		s_read_max |=> busRdata == {16'h0, $past(queueSizeLimits[fs_r.sel*16 +: 16])};
	endproperty
	a_max: assert property (p_max) else $error("max size wrong");

	property p_base;
		@(posedge mclk) disable iff (reset)
		qs.wrFrame |=> queueBaseAddr == (64'($past(busWdata)) * 64'(fs_r.pageBytes));
	endproperty
	a_base: assert property (p_base) else $error("base address wrong");

	// Device reset pulse, and the select and flags it clears
	property p_dev_reset;
		@(posedge mclk) disable iff (reset)
		s_zero_status |=> deviceReset;
	endproperty
	a_dev_reset: assert property (p_dev_reset) else $error("no reset pulse");

	property p_reset_state;
		@(posedge mclk) disable iff (reset)
		s_zero_status |=> (qs.index == '0) && !irqOut;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state kept over reset");

	// Bus answer: one pulse after each read, zero data on idle cycles
	property p_read_answer;
		@(posedge mclk) disable iff (reset)
		rd |=> busRvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_idle_zero;
		@(posedge mclk) disable iff (reset)
		!rd |=> !busRvalid && (busRdata == 32'h0);
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("idle bus not quiet");

	// An unavailable queue must read back a zero limit
	property p_max_zero;
		@(posedge mclk) disable iff (reset)
		(rd && hit(busAddr, OFF_QMAX) && (limitOf(fs_r.sel, queueSizeLimits) == 32'h0))
		|=> busRdata == 32'h0;
	endproperty
	a_max_zero: assert property (p_max_zero) else $error("unavailable queue nonzero");

	// Interrupt flags: an event raises the line unless a device reset clears it
	property p_irq_used;
		@(posedge mclk) disable iff (reset)
		(usedEvent && !zeroSt) |=> irqOut;
	endproperty
	a_irq_used: assert property (p_irq_used) else $error("used event lost");

	// Events win over a same-cycle acknowledge, so only a quiet cycle is checked
	property p_irq_clear;
		@(posedge mclk) disable iff (reset)
		(wr && hit(busAddr, OFF_IRQ_CLEAR) && !usedEvent && !configEvent)
		|=> ((fs_r.irqFlags & $past(busWdata[1:0])) == 2'b00);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared");

	property p_kick;
		@(posedge mclk) disable iff (reset)
		(wr && hit(busAddr, OFF_KICK)) |=> kickValid && (kickQueue == $past(busWdata));
	endproperty
	a_kick: assert property (p_kick) else $error("kick not raised");
endmodule : legacy_mmio_queue_regs

/* File: src/queue_regs_pkg.sv */
// Purpose: Constants and types for the legacy memory-mapped queue register block.
// Assumes: 32-bit word bus, byte offsets as printed, four queues.
// Notes: All offsets are byte addresses of aligned words.
// What this block does
// - A write to the page frame register stores the page index where the selected queue begins.
// - A read of the page frame register returns the selected queue's page, non-zero meaning active.
// - Page frame reads and writes act on the queue last chosen by the select register.
// - The status register reads back its flags and a non-zero write sets them.
// - A zero write to the status register resets the device and clears every queue's page frame.
// - Both sides place the used ring at the boundary held in the alignment register.
// - An unavailable queue reports a maximum size of zero and software then leaves it unused.
// - A write to the select register picks the queue for the size, alignment and frame registers.
// - The maximum size register returns the selected queue's limit, or zero if unavailable.
// - The device forms the queue's first guest address from page size and stored page frame.
// - A write to the alignment register stores the selected queue's used ring boundary.
package queue_regs_pkg;
	localparam int          NUM_QUEUES     = 4;
	localparam int          QIDX_W         = 2;
	localparam logic [11:0] OFF_PAGE_BYTES = 12'h028;
	localparam logic [11:0] OFF_QSEL       = 12'h030;
	localparam logic [11:0] OFF_QMAX       = 12'h034;
	localparam logic [11:0] OFF_QNUM       = 12'h038;
	localparam logic [11:0] OFF_QALIGN     = 12'h03c;
	localparam logic [11:0] OFF_QPFN       = 12'h040;
	localparam logic [11:0] OFF_KICK       = 12'h050;
	localparam logic [11:0] OFF_IRQ_FLAGS  = 12'h060;
	localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h064;
	localparam logic [11:0] OFF_STATUS     = 12'h070;
	localparam logic [11:0] OFF_CONFIG     = 12'h100;
	localparam int          CONFIG_WORDS   = 4;
	localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
	localparam logic [31:0] RST_PAGE_BYTES = 32'h0000_1000;
	localparam logic [1:0]  IRQ_USED_BIT   = 2'h1;
	localparam logic [1:0]  IRQ_CFG_BIT    = 2'h2;

	typedef struct packed {
		logic [31:0] pageFrame;
		logic [31:0] sizeInUse;
		logic [31:0] alignment;
	} queue_entry_t;
endpackage : queue_regs_pkg

/* File: src/queue_store_if.sv */
`timescale 1ns/1ps
// Purpose: Carries per-queue access between the register front end and the queue store.
// Assumes: One access per cycle, index already selected.
// Notes: Read data is combinational from the store's flip-flops.
interface queue_store_if;
	import queue_regs_pkg::*;
	logic [QIDX_W-1:0] index;
	logic              wrFrame;
	logic              wrSize;
	logic              wrAlign;
	logic              clearAll;
	logic [31:0]       wdata;
	queue_entry_t      entry;
	modport front (output index, wrFrame, wrSize, wrAlign, clearAll, wdata, input entry);
	modport store (input index, wrFrame, wrSize, wrAlign, clearAll, wdata, output entry);
endinterface : queue_store_if

/* File: src/queue_store.sv */
`timescale 1ns/1ps
// Purpose: Per-queue frame, size and alignment storage.
// Assumes: Driven by the register front end only.
// Notes: Device reset by status write wins over any same-cycle frame write.
module queue_store (
	input  wire logic     mclk,
	input  wire logic     reset,
	queue_store_if.store  qs
);
	import queue_regs_pkg::*;

	typedef struct packed {
		queue_entry_t [NUM_QUEUES-1:0] q;
	} store_state_t;

	store_state_t st_r;
	store_state_t st_nxt;

	// Next-state for the selected queue entry, or every queue's frame on clearAll
	always_comb begin
		st_nxt = st_r;
		if (qs.clearAll) begin
			for (int i = 0; i < NUM_QUEUES; i++) begin
				st_nxt.q[i].pageFrame = RST_ZERO;
			end
		end else begin
			if (qs.wrFrame)
				st_nxt.q[qs.index].pageFrame = qs.wdata;
			if (qs.wrSize)
				st_nxt.q[qs.index].sizeInUse = qs.wdata;
			if (qs.wrAlign)
				st_nxt.q[qs.index].alignment = qs.wdata;
		end
	end

	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign qs.entry = st_r.q[qs.index];

	property p_clear_all;
		@(posedge mclk) disable iff (reset)
		qs.clearAll |=> (st_r.q[0].pageFrame == 32'h0) && (st_r.q[NUM_QUEUES-1].pageFrame == 32'h0);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("frames not cleared");

	property p_frame_store;
		@(posedge mclk) disable iff (reset)
		(qs.wrFrame && !qs.clearAll) |=> (st_r.q[$past(qs.index)].pageFrame == $past(qs.wdata));
	endproperty
	a_frame_store: assert property (p_frame_store) else $error("frame not stored");

	property p_align_store;
		@(posedge mclk) disable iff (reset)
		(qs.wrAlign && !qs.clearAll) |=> (st_r.q[$past(qs.index)].alignment == $past(qs.wdata));
	endproperty
	a_align_store: assert property (p_align_store) else $error("alignment not stored");
endmodule : queue_store

/* File: testbench/tb_legacy_mmio_queue_regs.sv */
// Purpose: Self-checking bench for the legacy queue register block.
// Assumes: Reads answer within a few cycles; register writes act on the next cycle.
// Notes: Event inputs are pulsed by the bench; one pulse meets an acknowledge in its cycle.
`timescale 1ns/1ps
module tb_legacy_mmio_queue_regs;
	import queue_regs_pkg::*;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        busSel = 1'b0;
	logic        busWrite = 1'b0;
	logic [11:0] busAddr = 12'h000;
	logic [31:0] busWdata = 32'h0000_0000;
	logic [31:0] busRdata;
	logic        busRvalid;
	logic [63:0] limits = {16'h0040, 16'h0000, 16'h0100, 16'h0080};
	logic        irqOut;
	logic        kickValid;
	logic [31:0] kickQueue;
	logic [63:0] queueBaseAddr;
	logic [31:0] queueAlignOut;
	logic        deviceReset;
	logic        usedEvent = 1'b0;
	logic        configEvent = 1'b0;
	logic [31:0] rv;
	int          n_fail = 0;
	int          n_compared = 0;

	legacy_mmio_queue_regs u_legacy_mmio_queue_regs (.mclk(mclk), .reset(reset),
		.busSel(busSel), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
		.busRdata(busRdata), .busRvalid(busRvalid), .queueSizeLimits(limits),
		.usedEvent(usedEvent), .configEvent(configEvent), .irqOut(irqOut),
		.kickValid(kickValid), .kickQueue(kickQueue), .queueBaseAddr(queueBaseAddr),
		.queueAlignOut(queueAlignOut), .deviceReset(deviceReset));

	// 25 MHz clock
	always #20 mclk = ~mclk;

	// Verdict and end of run; also reached from a timed-out wait
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One write, held until the taking edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		busSel   <= 1'b1;
		busWrite <= 1'b1;
		busAddr  <= a;
		busWdata <= d;
		@(posedge mclk);
		busSel   <= 1'b0;
		#1;
	endtask : wr

	// One read; bounded wait for the answer pulse
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		bit got;
		got = 1'b0;
		@(posedge mclk);
		busSel   <= 1'b1;
		busWrite <= 1'b0;
		busAddr  <= a;
		@(posedge mclk);
		busSel   <= 1'b0;
		for (int i = 0; i < 4 && !got; i++) begin
			#1;
			if (busRvalid === 1'b1) begin
				got = 1'b1;
				d   = busRdata;
			end else begin
				@(posedge mclk);
			end
		end
		if (!got) begin
			check(64'(got), 64'h1);
			summarize();
		end
	endtask : rd

	// Per-queue frames land in the selected queue only; default page size in base
	task automatic t_frames();
		wr(OFF_PAGE_BYTES, 32'h0000_1000);
		for (int q = 0; q < NUM_QUEUES; q++) begin
			wr(OFF_QSEL, q);
			rd(OFF_QPFN, rv);
			check(rv, 0);
			wr(OFF_QPFN, 32'h0000_0100 + q);
		end
		for (int q = NUM_QUEUES - 1; q >= 0; q--) begin
			wr(OFF_QSEL, q);
			rd(OFF_QPFN, rv);
			check(rv, 32'h0000_0100 + q);
			check(queueBaseAddr, 64'(32'h0000_0100 + q) * 64'h1000);
		end
		rd(12'h0f0, rv);
		check(rv, 0);
	endtask : t_frames

	// Size limits follow the select, zero marks an unavailable queue
	task automatic t_limits();
		for (int q = 0; q < NUM_QUEUES; q++) begin
			wr(OFF_QSEL, q);
			rd(OFF_QMAX, rv);
			check(rv, {16'h0000, limits[q*16 +: 16]});
		end
		wr(OFF_QSEL, 2);
		rd(OFF_QMAX, rv);
		check(rv, 32'h0000_0000);
	endtask : t_limits

	// Stop queue 1, set it up again in driver order, then kick and config words
	task automatic t_layout();
		wr(OFF_QSEL, 1);
		wr(OFF_QPFN, 32'h0000_0000);
		rd(OFF_QPFN, rv);
		check(rv, 0);
		wr(OFF_PAGE_BYTES, 32'h0000_2000);
		rd(OFF_QMAX, rv);
		check(rv, 32'h0000_0100);
		wr(OFF_QNUM, 32'h0000_0080);
		wr(OFF_QALIGN, 32'h0000_1000);
		check(queueAlignOut, 32'h0000_1000);
		wr(OFF_QPFN, 32'h0000_0101);
		check(queueBaseAddr, 64'h0000_0000_0020_2000);
		rd(OFF_QPFN, rv);
		check(rv, 32'h0000_0101);
		wr(OFF_QSEL, 2);
		check(queueAlignOut, 32'h0000_0000);
		wr(OFF_KICK, 32'h0000_0002);
		check(kickValid, 1'b1);
		check(kickQueue, 32'h0000_0002);
		@(posedge mclk);
		#1;
		check(kickValid, 1'b0);
		wr(OFF_CONFIG + 12'h004, 32'h1234_5678);
		rd(OFF_CONFIG + 12'h004, rv);
		check(rv, 32'h1234_5678);
	endtask : t_layout

	// Events raise the line; an event beats an acknowledge in the same cycle
	task automatic t_irq();
		@(posedge mclk);
		usedEvent <= 1'b1;
		@(posedge mclk);
		usedEvent <= 1'b0;
		#1;
		check(irqOut, 1'b1);
		rd(OFF_IRQ_FLAGS, rv);
		check(rv, 32'h0000_0001);
		@(posedge mclk);
		configEvent <= 1'b1;
		busSel      <= 1'b1;
		busWrite    <= 1'b1;
		busAddr     <= OFF_IRQ_CLEAR;
		busWdata    <= 32'h0000_0003;
		@(posedge mclk);
		configEvent <= 1'b0;
		busSel      <= 1'b0;
		#1;
		rd(OFF_IRQ_FLAGS, rv);
		check(rv, 32'h0000_0002);
		wr(OFF_IRQ_CLEAR, 32'h0000_0002);
		check(irqOut, 1'b0);
	endtask : t_irq

	// Status flags, then a zero write resets every queue frame
	task automatic t_status();
		wr(OFF_STATUS, 32'h0000_0007);
		rd(OFF_STATUS, rv);
		check(rv, 32'h0000_0007);
		check(irqOut, 1'b0);
		wr(OFF_STATUS, 32'h0000_0000);
		check(deviceReset, 1'b1);
		rd(OFF_QPFN, rv);
		check(rv, 0);
		check(deviceReset, 1'b0);
		for (int q = 0; q < NUM_QUEUES; q++) begin
			wr(OFF_QSEL, q);
			rd(OFF_QPFN, rv);
			check(rv, 0);
		end
		rd(OFF_STATUS, rv);
		check(rv, 0);
	endtask : t_status

	// Main sequence: reset for two cycles, then each scenario
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		t_frames();
		t_limits();
		t_layout();
		t_irq();
		t_status();
		summarize();
	end
endmodule : tb_legacy_mmio_queue_regs
